/* File: verilog/fpm_pkg.sv */
// Package of constants and types for the flash bus pin port
// Summary of operation
// - Non-multiplexed option: full word address on dedicated inputs selects the location.
// - Host drives data or commands on writes; device drives data on reads.
// - AD multiplexed option (mode bit 4 clear): address bits 16 and up stay on dedicated inputs.
// - Shared pins carry low address in address phase, then data.
// - Die select low selects the device; high deselects into standby.
// - Burst clock only paces synchronous burst read output.
// - Address inputs accepted only while address valid is low.
// - Synchronous burst reads capture address on address valid rising edge.
// - Write protect low enables block lock-down; high disables it.
// - Reset low inhibits every operation; host holds it high normally.
// - Wait output polarity is configurable, active high or active low.
// - Wait asserted while data invalid, deasserted when valid.
// - Mode bit 4 clear, output enable high: shared pins carry address 15:0.
// - Address-address-data mode, output enable high: first phase carries address 15:0.
// - Address-address-data mode, output enable low: pins 9:0 carry address 25:16.
package fpm_pkg;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned ADDR_W        = 26;
   localparam int unsigned LOW_ADDR_W    = 16;
   localparam int unsigned HIGH_PHASE_W  = 10;
   localparam int unsigned CFG_W         = 16;
   localparam int unsigned CFG_AAD_BIT   = 4;
   localparam int unsigned CFG_WAITP_BIT = 10;
   localparam int unsigned CFG_SYNC_BIT  = 15;
   localparam logic [15:0] CFG_RESET     = 16'hbfcf;
   localparam int unsigned LATENCY_CYC   = 3;
   localparam int unsigned BURST_LEN     = 4;

   typedef enum logic [1:0] {
      FPM_MUX_NONE,
      FPM_MUX_AD,
      FPM_MUX_AAD
   } fpm_mux_t;

   typedef enum {
      FPM_IDLE,
      FPM_LATENCY,
      FPM_BURST
   } fpm_state_t;
endpackage : fpm_pkg

/* File: verilog/fpm_addr_latch.sv */
// Address assembly and capture for all pin options
`timescale 1ns/1ps
module fpm_addr_latch
   import fpm_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // Pins and mode
   input  wire logic              i_mux_en,
   input  wire logic              i_aad_mode,
   input  wire logic              i_sel,
   input  wire logic              i_address_valid_n,
   input  wire logic              i_oe_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_adq,
   // Results
   output logic      [ADDR_W-1:0] o_addr,
   output logic                   o_capture
);
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic              strb_q;
   logic              strb_d;
   logic              cap_q;
   logic              cap_d;

   // Track the strobe and merge address pieces while it is low
   always_comb begin
      addr_d = addr_q;
      strb_d = i_address_valid_n;
      cap_d  = i_sel && i_address_valid_n && !strb_q;
      if (i_sel && !i_address_valid_n) begin
         if (!i_mux_en) begin
            addr_d = i_addr;
         end else if (!i_aad_mode) begin
            addr_d = {i_addr[ADDR_W-1:LOW_ADDR_W], i_adq};
         end else if (i_oe_n) begin
            addr_d[LOW_ADDR_W-1:0] = i_adq;
         end else begin
            // Upper pins 15:10 are ignored in this phase; dedicated inputs tied low
            addr_d[ADDR_W-1:LOW_ADDR_W] = i_adq[HIGH_PHASE_W-1:0];
         end
      end
   end

   // Registers only
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         addr_q <= '0;
         strb_q <= 1'b1;
         cap_q  <= 1'b0;
      end else begin
         addr_q <= addr_d;
         strb_q <= strb_d;
         cap_q  <= cap_d;
      end
   end

   assign o_addr    = addr_q;
   assign o_capture = cap_q;
endmodule : fpm_addr_latch

/* File: verilog/fpm_out_drive.sv */
// Data pin drive and wait polarity
`timescale 1ns/1ps
module fpm_out_drive
   import fpm_pkg::*;
(
   // Controls
   input  wire logic              i_sel,
   input  wire logic              i_oe_n,
   input  wire logic              i_we_n,
   input  wire logic              i_valid,
   input  wire logic              i_wait_high,
   // Pin side
   output logic                   o_dq_oe,
   output logic                   o_wait
);
   // Drive only for a selected read; everything else leaves the bus free
   assign o_dq_oe = i_sel && !i_oe_n && i_we_n;
   // Asserted while data is invalid; polarity bit set means active high, so the
   // idle level is the inverse of the polarity bit and a port that is not driving never shows a stall
   assign o_wait  = (o_dq_oe && !i_valid) ~^ i_wait_high;
endmodule : fpm_out_drive

/* File: verilog/fpm_port.sv */
// Top: flash bus pin port with mux options and burst pacing
`timescale 1ns/1ps
module fpm_port
   import fpm_pkg::*;
#(
   parameter int unsigned LATENCY = LATENCY_CYC,
   parameter int unsigned BURST   = BURST_LEN
)(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // Bus control pins
   input  wire logic              i_reset_n,
   input  wire logic              i_ce_n,
   input  wire logic              i_oe_n,
   input  wire logic              i_we_n,
   input  wire logic              i_address_valid_n,
   input  wire logic              i_wp_n,
   input  wire logic              i_burst_clk,
   // Address and data pins
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_dq,
   output logic      [DATA_W-1:0] o_dq,
   output logic                   o_dq_oe,
   output logic                   o_wait,
   // Strap and configuration
   input  wire logic              i_mux_en,
   input  wire logic [CFG_W-1:0]  i_read_config_register,
   // Array side
   output logic      [ADDR_W-1:0] o_array_addr,
   output logic                   o_array_rd,
   input  wire logic [DATA_W-1:0] i_array_data,
   output logic                   o_array_wr,
   output logic      [DATA_W-1:0] o_array_wdata,
   output logic                   o_lockdown_en,
   output logic                   o_standby
);
   if (LATENCY < 1 || LATENCY > 15 || BURST < 1 || BURST > 255) begin : g_chk
      $error("fpm_port: unsupported latency or burst length");
   end

   logic              sel;
   logic              capture;
   logic [ADDR_W-1:0] cap_addr;
   logic              sync_mode;
   fpm_state_t        state_q;
   fpm_state_t        state_d;
   logic [7:0]        cnt_q;
   logic [7:0]        cnt_d;
   logic [ADDR_W-1:0] baddr_q;
   logic [ADDR_W-1:0] baddr_d;
   logic              bclk_q;
   logic              bclk_d;
   logic              valid_q;
   logic              valid_d;
   logic [DATA_W-1:0] dq_q;
   logic [DATA_W-1:0] dq_d;
   logic              we_q;
   logic              we_d;
   logic              wr_q;
   logic              wr_d;
   logic [DATA_W-1:0] wdat_q;
   logic [DATA_W-1:0] wdat_d;
   logic              wp_q;
   logic              wp_d;
   logic              bedge;

   // Reset pin inhibits everything; die select gates all activity except the write protect lock-down
   assign sel       = i_reset_n && !i_ce_n;
   assign sync_mode = !i_read_config_register[CFG_SYNC_BIT];
   assign bedge     = i_burst_clk && !bclk_q;

   fpm_addr_latch u_addr (
      .i_clk             (i_clk),
      .i_reset           (i_reset || !i_reset_n),
      .i_mux_en          (i_mux_en),
      .i_aad_mode        (i_read_config_register[CFG_AAD_BIT]),
      .i_sel             (sel),
      .i_address_valid_n (i_address_valid_n),
      .i_oe_n            (i_oe_n),
      .i_addr            (i_addr),
      .i_adq             (i_dq),
      .o_addr            (cap_addr),
      .o_capture         (capture)
   );

   fpm_out_drive u_drv (
      .i_sel       (sel),
      .i_oe_n      (i_oe_n),
      .i_we_n      (i_we_n),
      .i_valid     (valid_q),
      .i_wait_high (i_read_config_register[CFG_WAITP_BIT]),
      .o_dq_oe     (o_dq_oe),
      .o_wait      (o_wait)
   );

   // Read sequencing: async reads follow the address, sync reads pace on burst clock
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      baddr_d = baddr_q;
      valid_d = valid_q;
      dq_d    = dq_q;
      bclk_d  = i_burst_clk;
      if (!sel || i_oe_n) begin
         state_d = FPM_IDLE;
         valid_d = 1'b0;
      end else if (!sync_mode) begin
         baddr_d = cap_addr;
         dq_d    = i_array_data;
         valid_d = 1'b1;
      end else begin
         unique case (state_q)
            FPM_IDLE: begin
               valid_d = 1'b0;
               if (capture) begin
                  baddr_d = cap_addr;
                  cnt_d   = 8'(LATENCY);
                  state_d = FPM_LATENCY;
               end
            end
            FPM_LATENCY: begin
               if (bedge) begin
                  if (cnt_q == 8'h01) begin
                     dq_d    = i_array_data;
                     valid_d = 1'b1;
                     cnt_d   = 8'(BURST);
                     state_d = FPM_BURST;
                  end else begin
                     cnt_d = cnt_q - 8'h01;
                  end
               end
            end
            FPM_BURST: begin
               if (bedge) begin
                  if (cnt_q == 8'h01) begin
                     // Burst done: hold last word, ready for a new address
                     state_d = FPM_IDLE;
                  end else begin
                     baddr_d = baddr_q + ADDR_W'(1);
                     cnt_d   = cnt_q - 8'h01;
                  end
               end
               dq_d = i_array_data;
            end
         endcase
         if (capture && state_q != FPM_IDLE) begin
            baddr_d = cap_addr;
            cnt_d   = 8'(LATENCY);
            valid_d = 1'b0;
            state_d = FPM_LATENCY;
         end
      end
   end

   // Write capture on the rising edge of the write strobe
   always_comb begin
      we_d   = i_we_n;
      wr_d   = sel && i_we_n && !we_q && i_oe_n;
      wdat_d = wr_d ? i_dq : wdat_q;
      wp_d   = !i_wp_n;
   end

   // Registers only
   always_ff @(posedge i_clk) begin
      if (i_reset || !i_reset_n) begin
         state_q <= FPM_IDLE;
         cnt_q   <= 8'h00;
         baddr_q <= '0;
         bclk_q  <= 1'b0;
         valid_q <= 1'b0;
         dq_q    <= '0;
         we_q    <= 1'b1;
         wr_q    <= 1'b0;
         wdat_q  <= '0;
         wp_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         baddr_q <= baddr_d;
         bclk_q  <= bclk_d;
         valid_q <= valid_d;
         dq_q    <= dq_d;
         we_q    <= we_d;
         wr_q    <= wr_d;
         wdat_q  <= wdat_d;
         wp_q    <= wp_d;
      end
   end

   // Outputs
   assign o_dq          = dq_q;
   assign o_array_addr  = (state_q == FPM_IDLE) ? cap_addr : baddr_q;
   assign o_array_rd    = sel && !i_oe_n && i_we_n;
   assign o_array_wr    = wr_q;
   assign o_array_wdata = wdat_q;
   assign o_lockdown_en = wp_q;
   assign o_standby     = !sel;
endmodule : fpm_port

/* File: tb/fpm_port_assertions.sv */
// Checker of the flash bus pin port, watching top-level pins only
`timescale 1ns/1ps
module fpm_port_chk
   import fpm_pkg::*;
(
   // Clock and reset
   input wire logic              i_clk,
   input wire logic              i_reset,
   // Watched pins
   input wire logic              i_reset_n,
   input wire logic              i_ce_n,
   input wire logic              i_oe_n,
   input wire logic              i_we_n,
   input wire logic              i_address_valid_n,
   input wire logic              i_wp_n,
   input wire logic [DATA_W-1:0] i_dq,
   input wire logic [CFG_W-1:0]  i_read_config_register,
   input wire logic              o_dq_oe,
   input wire logic              o_wait,
   input wire logic [ADDR_W-1:0] o_array_addr,
   input wire logic              o_array_wr,
   input wire logic [DATA_W-1:0] o_array_wdata,
   input wire logic              o_lockdown_en,
   input wire logic              o_standby
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // Drive and select relations are combinational, so they hold every cycle; lock-down follows write protect one cycle later
   oe_gate_a: assert property (o_dq_oe |-> !i_ce_n && !i_oe_n && i_we_n)
      else $error("data drive outside read");
   oe_on_a: assert property (i_reset_n && !i_ce_n && !i_oe_n && i_we_n |-> o_dq_oe)
      else $error("read without data drive");
   standby_a: assert property (o_standby == !(i_reset_n && !i_ce_n))
      else $error("standby mismatch");
   wait_idle_a: assert property (!o_dq_oe |-> o_wait == !i_read_config_register[CFG_WAITP_BIT])
      else $error("wait not deasserted");
   lockdown_a: assert property (!$past(i_reset) && $past(i_reset_n)
      |-> o_lockdown_en == !$past(i_wp_n))
      else $error("lock-down level wrong");
   // Write is taken on the strobe rising edge only
   wr_take_a: assert property ($rose(i_we_n) && !$past(i_reset) && !i_ce_n && i_oe_n && i_reset_n
      |=> o_array_wr && o_array_wdata == $past(i_dq))
      else $error("write not taken");
   wr_single_a: assert property (o_array_wr |=> !o_array_wr)
      else $error("write pulse too long");
   wr_gate_a: assert property (i_ce_n || !i_reset_n |=> !o_array_wr)
      else $error("write while inhibited");
   addr_hold_a: assert property (i_address_valid_n && $past(i_address_valid_n)
      && $past(i_address_valid_n, 2) && i_read_config_register[CFG_SYNC_BIT]
      && !$past(i_reset) && $past(i_reset_n) |-> $stable(o_array_addr))
      else $error("address moved while not valid");

   // Main scenarios
   wr_seen_c: cover property (o_array_wr);
   rd_seen_c: cover property (o_dq_oe && !o_wait);
   wake_seen_c: cover property (o_standby ##1 !o_standby);
   burst_seen_c: cover property (!i_read_config_register[CFG_SYNC_BIT] && o_dq_oe && $fell(o_wait));
endmodule : fpm_port_chk

bind fpm_port fpm_port_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_reset_n(i_reset_n),
   .i_ce_n(i_ce_n), .i_oe_n(i_oe_n), .i_we_n(i_we_n), .i_address_valid_n(i_address_valid_n),
   .i_wp_n(i_wp_n), .i_dq(i_dq), .i_read_config_register(i_read_config_register),
   .o_dq_oe(o_dq_oe), .o_wait(o_wait), .o_array_addr(o_array_addr), .o_array_wr(o_array_wr),
   .o_array_wdata(o_array_wdata), .o_lockdown_en(o_lockdown_en), .o_standby(o_standby));

/* File: tb/fpm_host_model.sv */
// Host controller model that runs bus cycles on the port pins
`timescale 1ns/1ps
module fpm_host_model (
   // Clock and mode straps
   input  wire logic        i_clk,
   input  wire logic        i_mux_en,
   input  wire logic        i_aad_mode,
   // Pins toward the port
   output logic             o_ce_n,
   output logic             o_oe_n,
   output logic             o_we_n,
   output logic             o_address_valid_n,
   output logic [25:0]      o_addr,
   output logic [15:0]      o_dq
);
   initial begin
      o_ce_n = 1'b1;
      o_oe_n = 1'b1;
      o_we_n = 1'b1;
      o_address_valid_n = 1'b1;
      o_addr = 26'h0;
      o_dq = 16'h0;
   end

   // One transfer; select stays low afterwards so read data can be inspected
   task automatic xfer(input logic wr, input logic [25:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_ce_n = 1'b0;
      o_address_valid_n = 1'b0;
      o_oe_n = 1'b1;
      o_addr = !i_mux_en ? a : (i_aad_mode ? 26'h0 : {a[25:16], 16'h0});
      o_dq = i_mux_en ? a[15:0] : ~d;
      if (i_aad_mode) begin
         @(negedge i_clk);
         o_oe_n = 1'b0;
         o_dq = {6'h2a, a[25:16]};
      end
      @(negedge i_clk);
      o_address_valid_n = 1'b1;
      o_oe_n = wr;
      o_we_n = !wr;
      o_dq = wr ? d : ~o_dq;
      @(negedge i_clk);
      o_we_n = 1'b1;
      repeat (3) @(negedge i_clk);
   endtask : xfer

   // Deselect; released pins show no stale value
   task automatic idle();
      o_ce_n = 1'b1;
      o_oe_n = 1'b1;
      o_dq = ~o_dq;
   endtask : idle
endmodule : fpm_host_model

/* File: tb/tb_flash_bus_pin_port_mux.sv */
// Self-checking testbench of the flash bus pin port
`timescale 1ns/1ps
module tb_flash_bus_pin_port_mux;
   import fpm_pkg::*;
   logic        i_clk, i_reset, reset_n, wp_n, mux_en;
   logic [15:0] cfg, d, o_dq, wdata;
   logic [25:0] a, addr, arr_addr;
   logic [15:0] dq_in;
   logic        ce_n, oe_n, we_n, avld_n, dq_oe, o_wait, arr_wr, arr_rd, lock, stby;
   logic        bclk = 1'b0;
   logic        bclk_run = 1'b0;
   logic [41:0] exp_q[$];
   logic [41:0] rd_q[$];
   int          bad_count, total_checks, cyc;

   function automatic logic [15:0] f(input logic [25:0] x);
      return x[15:0] ^ {x[25:16], 6'h15};
   endfunction : f

   fpm_host_model host (.i_clk(i_clk), .i_mux_en(mux_en), .i_aad_mode(cfg[4]), .o_ce_n(ce_n),
      .o_oe_n(oe_n), .o_we_n(we_n), .o_address_valid_n(avld_n), .o_addr(addr), .o_dq(dq_in));
   fpm_port dut (.i_clk(i_clk), .i_reset(i_reset), .i_reset_n(reset_n), .i_ce_n(ce_n),
      .i_oe_n(oe_n), .i_we_n(we_n), .i_address_valid_n(avld_n), .i_wp_n(wp_n),
      .i_burst_clk(bclk), .i_addr(addr), .i_dq(dq_in), .o_dq(o_dq), .o_dq_oe(dq_oe),
      .o_wait(o_wait), .i_mux_en(mux_en), .i_read_config_register(cfg),
      .o_array_addr(arr_addr), .o_array_rd(arr_rd), .i_array_data(f(arr_addr)),
      .o_array_wr(arr_wr), .o_array_wdata(wdata), .o_lockdown_en(lock), .o_standby(stby));

   task automatic chk(input string nm, input logic [41:0] seen, input logic [41:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Hang guard, well above the roughly 210 cycles the tests need
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 6000) begin
         bad_count++;
         close_out();
      end
   end

   // Burst clock at half the system rate, parked low between bursts
   always @(negedge i_clk) begin
      bclk <= bclk_run ? !bclk : 1'b0;
   end

   // Each burst clock rise with valid data takes the oldest noted burst word
   always @(posedge bclk) begin
      if (dq_oe === 1'b1 && o_wait === 1'b0) begin
         if (rd_q.size() == 0) chk("burst_extra", 1'b1, 1'b0);
         else chk("burst_word", {arr_addr, o_dq}, rd_q.pop_front());
      end
   end

   // Each write pulse takes the oldest noted write
   always @(negedge i_clk) begin
      if (arr_wr === 1'b1) begin
         if (exp_q.size() == 0) chk("array_wr", 1'b1, 1'b0);
         else chk("array_wr", {arr_addr, wdata}, exp_q.pop_front());
      end
   end

   initial begin
      i_reset = 1'b1;
      reset_n = 1'b1;
      wp_n = 1'b1;
      mux_en = 1'b0;
      cfg = 16'h8400;
      void'($urandom(53));
      repeat (12) @(negedge i_clk);
      i_reset = 1'b0;
      // Non-mux, AD mux and address-address-data options
      for (int m = 0; m < 3; m++) begin
         mux_en = (m != 0);
         cfg = (m == 2) ? 16'h8410 : 16'h8400;
         for (int k = 0; k < 4; k++) begin
            a = 26'($urandom());
            d = 16'($urandom());
            exp_q.push_back({a, d});
            host.xfer(1'b1, a, d);
            host.idle();
            host.xfer(1'b0, a, d);
            chk("rd_addr", arr_addr, a);
            chk("rd_data", o_dq, f(a));
            chk("rd_pins", {dq_oe, o_wait, arr_rd}, 3'b101);
            host.idle();
         end
         $display("test mode %0d done", m);
      end
      // Synchronous burst read; word-aligned start keeps the four words distinct
      mux_en = 1'b0;
      cfg = 16'h0400;
      a = {24'($urandom()), 2'b00};
      for (int j = 0; j < BURST_LEN; j++) begin
         rd_q.push_back({a + 26'(j), f(a + 26'(j))});
      end
      bclk_run = 1'b1;
      host.xfer(1'b0, a, d);
      repeat (20) @(negedge i_clk);
      bclk_run = 1'b0;
      repeat (2) @(negedge i_clk);
      chk("burst_left", rd_q.size(), 0);
      chk("burst_wait", {dq_oe, o_wait}, 2'b11);
      host.idle();
      $display("test burst done");
      // Wait polarity flipped to active low
      mux_en = 1'b0;
      cfg = 16'h8000;
      host.xfer(1'b0, a, d);
      chk("wait_low_rd", {dq_oe, o_wait}, 2'b11);
      host.idle();
      @(negedge i_clk);
      chk("standby", stby, 1'b1);
      $display("test polarity done");
      // Pin reset inhibits a write
      reset_n = 1'b0;
      host.xfer(1'b1, a, ~d);
      chk("rst_standby", {stby, dq_oe, arr_rd}, 3'b100);
      host.idle();
      reset_n = 1'b1;
      // Write protect drives lock-down
      for (int w = 0; w < 2; w++) begin
         wp_n = w[0];
         repeat (2) @(negedge i_clk);
         chk("lockdown", lock, !w[0]);
      end
      $display("test reset and protect done");
      chk("wr_left", exp_q.size(), 0);
      close_out();
   end
endmodule : tb_flash_bus_pin_port_mux
